// [design/bsd_pkg.sv]
// Shared constants and types for the boundary-scan instruction decode block.
// Assumes a single device on the scan chain with a small fixed set of test pins.
package bsd_pkg;

	// ------------------------------------------------------------
	// Widths and boundary register layout
	// ------------------------------------------------------------
	localparam int BSD_IR_W = 4;
	localparam int BSD_ID_W = 32;
	localparam int BSD_NI = 4;
	localparam int BSD_NO = 4;
	localparam int BSD_BSR_W = BSD_NI + 2 * BSD_NO;
	// Input cells sit at the serial output end, then drive cells, then enable cells
	localparam int BSD_BSR_DRV_LSB = BSD_NI;
	localparam int BSD_BSR_OE_LSB = BSD_NI + BSD_NO;

	// ------------------------------------------------------------
	// Instruction codes and fixed patterns
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		BSD_IR_EXTEST = 4'h0,
		BSD_IR_SAMPLE = 4'h1,
		BSD_IR_IDCODE = 4'h2,
		BSD_IR_HIGHZ = 4'h4,
		BSD_IR_BYPASS = 4'hf
	} bsd_ir_t;
	// Two low bits of the captured instruction pattern are always 01
	localparam logic [3:0] BSD_IR_CAPTURE = 4'h1;
	localparam logic [3:0] BSD_IR_RESET = 4'h2;

	// Identification word: version[31:28], part[27:12], maker[11:1], one at bit 0
	localparam logic [3:0] BSD_ID_VERSION = 4'h1; // Arbitrary value
	localparam logic [15:0] BSD_ID_PART = 16'h0a5c; // Arbitrary value
	localparam logic [10:0] BSD_ID_MAKER = 11'h06e; // Arbitrary value
	localparam logic [31:0] BSD_ID_WORD = {BSD_ID_VERSION, BSD_ID_PART, BSD_ID_MAKER, 1'b1};

	// ------------------------------------------------------------
	// Controller states and pin modes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		BSD_TLR = 4'h0,
		BSD_RTI = 4'h1,
		BSD_SEL_DR = 4'h2,
		BSD_CAP_DR = 4'h3,
		BSD_SH_DR = 4'h4,
		BSD_EX1_DR = 4'h5,
		BSD_PA_DR = 4'h6,
		BSD_EX2_DR = 4'h7,
		BSD_UPD_DR = 4'h8,
		BSD_SEL_IR = 4'h9,
		BSD_CAP_IR = 4'ha,
		BSD_SH_IR = 4'hb,
		BSD_EX1_IR = 4'hc,
		BSD_PA_IR = 4'hd,
		BSD_EX2_IR = 4'he,
		BSD_UPD_IR = 4'hf
	} bsd_tap_state_t;

	typedef enum logic [1:0] {
		BSD_PM_NORMAL = 2'h0,
		BSD_PM_EXTEST = 2'h1,
		BSD_PM_HIGHZ = 2'h2
	} bsd_pin_mode_t;

	// Pin control word handed from the test clock to the system clock
	typedef struct packed {
		bsd_pin_mode_t mode;
		logic [BSD_NO-1:0] drv;
		logic [BSD_NO-1:0] oe;
	} bsd_xfer_t;
	localparam bsd_xfer_t BSD_XFER_RESET = '{mode: BSD_PM_NORMAL, drv: '0, oe: '0};

endpackage : bsd_pkg

// [design/bsd_xfer_sync.sv]
// Toggle-handshake word crossing from the test clock to the system clock.
// Assumes the source holds its word steady for several destination cycles after each toggle.
`timescale 1ns/1ps
`default_nettype none
module bsd_xfer_sync (
	input wire logic dst_clk, // Destination clock
	input wire logic dst_rst_n, // Synchronous reset, active low
	input wire bsd_pkg::bsd_xfer_t src_data, // Word held in the source domain
	input wire logic src_tgl, // Flips once per new word
	output bsd_pkg::bsd_xfer_t dst_data // Word as seen in the destination domain
);
	import bsd_pkg::*;

	logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
	bsd_xfer_t data_q, data_d;

	// ------------------------------------------------------------
	// Toggle synchroniser and word capture
	// ------------------------------------------------------------
	// Only s2 and s3 are compared; s1 may be metastable
	always_comb
	begin
		s1_d = src_tgl;
		s2_d = s1_q;
		s3_d = s2_q;
		data_d = (s2_q != s3_q) ? src_data : data_q;
	end

	always_ff @(posedge dst_clk)
	begin
		if (!dst_rst_n)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			data_q <= BSD_XFER_RESET;
		end
		else
		begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			data_q <= data_d;
		end
	end

	assign dst_data = data_q;

endmodule : bsd_xfer_sync
`default_nettype wire

// [design/bsd_tap_decode.sv]
// Test access port with instruction decode, data register selection and pin control.
// Assumes an external scan controller on tck/tms/tdi and core logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module bsd_tap_decode (
	input wire logic mclk, // System clock
	input wire logic rst_n, // System reset, synchronous, active low
	input wire logic tck, // Test clock
	input wire logic trst_n, // Test reset, sampled on tck, active low
	input wire logic tms, // Test mode select
	input wire logic tdi, // Test data in
	output logic tdo, // Test data out
	output logic tdo_oe, // Tdo driven when high
	input wire logic [bsd_pkg::BSD_NO-1:0] core_out, // Functional output values
	input wire logic [bsd_pkg::BSD_NO-1:0] core_oe, // Functional output enables
	output logic [bsd_pkg::BSD_NI-1:0] core_in, // Synchronised input pins to core
	input wire logic [bsd_pkg::BSD_NI-1:0] pin_in, // Input pins
	output logic [bsd_pkg::BSD_NO-1:0] pin_out, // Output pin values
	output logic [bsd_pkg::BSD_NO-1:0] pin_oe // Output pin enables
);
	import bsd_pkg::*;

	// ------------------------------------------------------------
	// Declarations: test clock domain first, then system clock domain
	// ------------------------------------------------------------
	bsd_tap_state_t tap_q, tap_d;
	logic [BSD_IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
	logic [BSD_BSR_W-1:0] bsr_sh_q, bsr_sh_d;
	logic [BSD_NO-1:0] upd_drv_q, upd_drv_d, upd_oe_q, upd_oe_d;
	logic [BSD_ID_W-1:0] id_sh_q, id_sh_d;
	logic byp_q, byp_d;
	bsd_xfer_t xfer_q, xfer_d;
	logic tgl_q, tgl_d;
	logic [BSD_NI-1:0] tin1_q, tin2_q;
	logic [BSD_NO-1:0] tdrv1_q, tdrv2_q, toe1_q, toe2_q;
	logic sel_bsr, sel_id, shifting;
	logic tdo_d, tdo_oe_d, tdo_q, tdo_oe_q;
	bsd_pin_mode_t mode_d;
	logic [BSD_NI-1:0] min1_q, min2_q;
	logic [BSD_NO-1:0] pout_q, pout_d, poe_q, poe_d;
	bsd_xfer_t xfer_m;

	// ------------------------------------------------------------
	// Controller state machine
	// ------------------------------------------------------------
	// Every state with tms high moves toward reset, so five high edges always land there
	always_comb
	begin
		case (tap_q)
			BSD_TLR: tap_d = tms ? BSD_TLR : BSD_RTI;
			BSD_RTI: tap_d = tms ? BSD_SEL_DR : BSD_RTI;
			BSD_SEL_DR: tap_d = tms ? BSD_SEL_IR : BSD_CAP_DR;
			BSD_CAP_DR: tap_d = tms ? BSD_EX1_DR : BSD_SH_DR;
			BSD_SH_DR: tap_d = tms ? BSD_EX1_DR : BSD_SH_DR;
			BSD_EX1_DR: tap_d = tms ? BSD_UPD_DR : BSD_PA_DR;
			BSD_PA_DR: tap_d = tms ? BSD_EX2_DR : BSD_PA_DR;
			BSD_EX2_DR: tap_d = tms ? BSD_UPD_DR : BSD_SH_DR;
			BSD_UPD_DR: tap_d = tms ? BSD_SEL_DR : BSD_RTI;
			BSD_SEL_IR: tap_d = tms ? BSD_TLR : BSD_CAP_IR;
			BSD_CAP_IR: tap_d = tms ? BSD_EX1_IR : BSD_SH_IR;
			BSD_SH_IR: tap_d = tms ? BSD_EX1_IR : BSD_SH_IR;
			BSD_EX1_IR: tap_d = tms ? BSD_UPD_IR : BSD_PA_IR;
			BSD_PA_IR: tap_d = tms ? BSD_EX2_IR : BSD_PA_IR;
			BSD_EX2_IR: tap_d = tms ? BSD_UPD_IR : BSD_SH_IR;
			BSD_UPD_IR: tap_d = tms ? BSD_SEL_DR : BSD_RTI;
			default: tap_d = BSD_TLR;
		endcase
	end

	always_ff @(posedge tck)
	begin
		if (!trst_n)
			tap_q <= BSD_TLR;
		else
			tap_q <= tap_d;
	end

	// ------------------------------------------------------------
	// Instruction register and decode
	// ------------------------------------------------------------
	// Boundary path for the two boundary instructions, id for idcode, else bypass
	always_comb
	begin
		sel_bsr = (ir_q == BSD_IR_EXTEST) || (ir_q == BSD_IR_SAMPLE);
		sel_id = (ir_q == BSD_IR_IDCODE);
		ir_sh_d = ir_sh_q;
		ir_d = ir_q;
		case (tap_q)
			BSD_TLR: ir_d = BSD_IR_RESET;
			BSD_CAP_IR: ir_sh_d = BSD_IR_CAPTURE;
			BSD_SH_IR: ir_sh_d = {tdi, ir_sh_q[BSD_IR_W-1:1]};
			BSD_UPD_IR: ir_d = ir_sh_q;
			default: ir_d = ir_q;
		endcase
	end

	always_ff @(posedge tck)
	begin
		if (!trst_n)
		begin
			ir_sh_q <= BSD_IR_CAPTURE;
			ir_q <= BSD_IR_RESET;
		end
		else
		begin
			ir_sh_q <= ir_sh_d;
			ir_q <= ir_d;
		end
	end

	// ------------------------------------------------------------
	// Pin snapshots into the test clock domain
	// ------------------------------------------------------------
	// Bits settle independently; a snapshot taken while a pin moves may mix old and new
	always_ff @(posedge tck)
	begin
		if (!trst_n)
		begin
			tin1_q <= '0;
			tin2_q <= '0;
			tdrv1_q <= '0;
			tdrv2_q <= '0;
			toe1_q <= '0;
			toe2_q <= '0;
		end
		else
		begin
			tin1_q <= pin_in;
			tin2_q <= tin1_q;
			tdrv1_q <= pout_q;
			tdrv2_q <= tdrv1_q;
			toe1_q <= poe_q;
			toe2_q <= toe1_q;
		end
	end

	// ------------------------------------------------------------
	// Data registers: boundary, identification, bypass
	// ------------------------------------------------------------
	always_comb
	begin
		bsr_sh_d = bsr_sh_q;
		id_sh_d = id_sh_q;
		byp_d = byp_q;
		upd_drv_d = upd_drv_q;
		upd_oe_d = upd_oe_q;
		case (tap_q)
			BSD_CAP_DR:
			begin
				if (sel_bsr)
					bsr_sh_d = {toe2_q, tdrv2_q, tin2_q};
				else if (sel_id)
					id_sh_d = BSD_ID_WORD;
				else
					byp_d = 1'b0;
			end
			BSD_SH_DR:
			begin
				if (sel_bsr)
					bsr_sh_d = {tdi, bsr_sh_q[BSD_BSR_W-1:1]};
				else if (sel_id)
					id_sh_d = {tdi, id_sh_q[BSD_ID_W-1:1]};
				else
					byp_d = tdi;
			end
			BSD_UPD_DR:
			begin
				// Update stage loads under sample too, which is what makes preload work
				if (sel_bsr)
				begin
					upd_drv_d = bsr_sh_q[BSD_BSR_DRV_LSB +: BSD_NO];
					upd_oe_d = bsr_sh_q[BSD_BSR_OE_LSB +: BSD_NO];
				end
			end
			default: byp_d = byp_q;
		endcase
	end

	always_ff @(posedge tck)
	begin
		if (!trst_n)
		begin
			bsr_sh_q <= '0;
			id_sh_q <= BSD_ID_WORD;
			byp_q <= 1'b0;
			upd_drv_q <= '0;
			upd_oe_q <= '0;
		end
		else
		begin
			bsr_sh_q <= bsr_sh_d;
			id_sh_q <= id_sh_d;
			byp_q <= byp_d;
			upd_drv_q <= upd_drv_d;
			upd_oe_q <= upd_oe_d;
		end
	end

	// ------------------------------------------------------------
	// Pin control word and its crossing toggle
	// ------------------------------------------------------------
	// A new word flips the toggle; the controller cannot change it again within three tck
	always_comb
	begin
		case (ir_d)
			BSD_IR_EXTEST: mode_d = BSD_PM_EXTEST;
			BSD_IR_HIGHZ: mode_d = BSD_PM_HIGHZ;
			default: mode_d = BSD_PM_NORMAL;
		endcase
		xfer_d = '{mode: mode_d, drv: upd_drv_d, oe: upd_oe_d};
		tgl_d = (xfer_d != xfer_q) ? ~tgl_q : tgl_q;
	end

	always_ff @(posedge tck)
	begin
		if (!trst_n)
		begin
			xfer_q <= BSD_XFER_RESET;
			tgl_q <= 1'b0;
		end
		else
		begin
			xfer_q <= xfer_d;
			tgl_q <= tgl_d;
		end
	end

	// ------------------------------------------------------------
	// Serial output on the falling test clock edge
	// ------------------------------------------------------------
	always_comb
	begin
		shifting = (tap_q == BSD_SH_IR) || (tap_q == BSD_SH_DR);
		if (tap_q == BSD_SH_IR)
			tdo_d = ir_sh_q[0];
		else if (sel_bsr)
			tdo_d = bsr_sh_q[0];
		else if (sel_id)
			tdo_d = id_sh_q[0];
		else
			tdo_d = byp_q;
		tdo_oe_d = shifting;
	end

	always_ff @(negedge tck)
	begin
		if (!trst_n)
		begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end
		else
		begin
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe = tdo_oe_q;

	// ------------------------------------------------------------
	// Crossing into the system clock domain
	// ------------------------------------------------------------
	bsd_xfer_sync u_xfer (
		.dst_clk(mclk),
		.dst_rst_n(rst_n),
		.src_data(xfer_q),
		.src_tgl(tgl_q),
		.dst_data(xfer_m)
	);

	// ------------------------------------------------------------
	// Pin drivers and input synchroniser on the system clock
	// ------------------------------------------------------------
	// Released pins keep the core value so only the enable has to change
	always_comb
	begin
		case (xfer_m.mode)
			BSD_PM_EXTEST:
			begin
				pout_d = xfer_m.drv;
				poe_d = xfer_m.oe;
			end
			BSD_PM_HIGHZ:
			begin
				pout_d = core_out;
				poe_d = '0;
			end
			default:
			begin
				pout_d = core_out;
				poe_d = core_oe;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			min1_q <= '0;
			min2_q <= '0;
			pout_q <= '0;
			poe_q <= '0;
		end
		else
		begin
			min1_q <= pin_in;
			min2_q <= min1_q;
			pout_q <= pout_d;
			poe_q <= poe_d;
		end
	end

	assign core_in = min2_q;
	assign pin_out = pout_q;
	assign pin_oe = poe_q;

endmodule : bsd_tap_decode
`default_nettype wire

// [testbench/bsd_tap_decode_props.sv]
// Concurrent checks on the boundary-scan decode block.
// Assumes it is bound to bsd_tap_decode and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module bsd_tap_decode_props (
	input wire logic mclk, // System clock
	input wire logic rst_n, // System reset, active low
	input wire logic tck, // Test clock
	input wire logic trst_n, // Test reset, active low
	input wire logic tms, // Mode select
	input wire logic tdi, // Serial in
	input wire logic tdo, // Serial out
	input wire logic tdo_oe, // Serial out enable
	input wire logic [bsd_pkg::BSD_NO-1:0] core_out, // Core values
	input wire logic [bsd_pkg::BSD_NO-1:0] core_oe, // Core enables
	input wire logic [bsd_pkg::BSD_NO-1:0] pin_out, // Pin values
	input wire logic [bsd_pkg::BSD_NO-1:0] pin_oe // Pin enables
);
	import bsd_pkg::*;
	// ------------------------------------------------------------
	// Shadow controller and instruction
	// ------------------------------------------------------------
	// Next state per current state, one nibble each, for tms low and high
	localparam logic [63:0] NXT0 = 64'h1bddbba146644311;
	localparam logic [63:0] NXT1 = 64'h2fefcc0287855920;
	logic [3:0] st_q, st_d, sh_q, sh_d, ir_q, ir_d;
	logic byp;
	// Mirrors the TAP so the serial checks know the state without probing inside
	always_comb
	begin
		st_d = tms ? NXT1[st_q*4+:4] : NXT0[st_q*4+:4];
		sh_d = (st_q == 4'hb) ? {tdi, sh_q[3:1]} : sh_q;
		ir_d = (st_q == 4'hf) ? sh_q : ir_q;
		if (st_q == 4'h0)
			ir_d = 4'h2;
		if (!trst_n)
		begin
			st_d = 4'h0;
			ir_d = 4'h2;
		end
	end
	always_ff @(posedge tck)
	begin
		st_q <= st_d;
		sh_q <= sh_d;
		ir_q <= ir_d;
	end
	assign byp = (ir_q != 4'h0) && (ir_q != 4'h1) && (ir_q != 4'h2);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_oe_shift;
		@(posedge tck) disable iff (!trst_n) tdo_oe == (st_q == 4'h4 || st_q == 4'hb);
	endproperty
	a_oe_shift: assert property (p_oe_shift) else $error("tdo enable outside shift states");
	property p_cap_ir;
		@(posedge tck) disable iff (!trst_n) (st_q == 4'ha) ##1 (st_q == 4'hb) |-> tdo;
	endproperty
	a_cap_ir: assert property (p_cap_ir) else $error("instruction capture lsb not one");
	property p_byp_zero;
		@(posedge tck) disable iff (!trst_n) (st_q == 4'h3 && byp) ##1 (st_q == 4'h4) |-> !tdo;
	endproperty
	a_byp_zero: assert property (p_byp_zero) else $error("bypass stage not zero after capture");
	property p_byp_pass;
		@(posedge tck) disable iff (!trst_n) (st_q == 4'h4 && byp) ##1 (st_q == 4'h4) |-> tdo == $past(tdi);
	endproperty
	a_byp_pass: assert property (p_byp_pass) else $error("bypass path not one stage");
	property p_id_lsb;
		@(posedge tck) disable iff (!trst_n) (st_q == 4'h3 && ir_q == 4'h2) ##1 (st_q == 4'h4) |-> tdo;
	endproperty
	a_id_lsb: assert property (p_id_lsb) else $error("identification lsb not one");
	property p_tlr;
		@(posedge tck) disable iff (!trst_n) tms [*5] |=> !tdo_oe;
	endproperty
	a_tlr: assert property (p_tlr) else $error("tdo driven after five tms high");
	property p_highz;
		@(posedge mclk) disable iff (!rst_n) (ir_q == 4'h4) [*8] |-> pin_oe == '0;
	endproperty
	a_highz: assert property (p_highz) else $error("pin enabled under high impedance");
	property p_normal;
		@(posedge mclk) disable iff (!rst_n) (ir_q != 4'h0 && ir_q != 4'h4) [*8]
			|-> pin_out == $past(core_out) && pin_oe == $past(core_oe);
	endproperty
	a_normal: assert property (p_normal) else $error("pins not following core");
	c_extest: cover property (@(posedge mclk) (ir_q == 4'h0) [*8]);
	c_highz_shift: cover property (@(posedge tck) ir_q == 4'h4 && st_q == 4'h4);
	c_id: cover property (@(posedge tck) st_q == 4'h3 && ir_q == 4'h2);
endmodule : bsd_tap_decode_props
bind bsd_tap_decode bsd_tap_decode_props u_props (.mclk(mclk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n),
	.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
	.pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// [testbench/bsd_jtag_host.sv]
// Test controller model driving the TAP pins.
// Assumes one task call at a time; tck stands still between calls.
`timescale 1ns/1ps
`default_nettype none
module bsd_jtag_host (
	output var logic tck, // Test clock, 80 ns
	output var logic trst_n, // Test reset
	output var logic tms, // Mode select
	output var logic tdi, // Serial in
	input wire logic tdo, // Serial out
	input wire logic tdo_oe // Serial out enable
);
	initial
	begin
		tck = 1'b0;
		trst_n = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One period; inputs move after the fall, tdo read just before the rise
	task automatic step(input logic m, input logic d, output logic o);
		#2;
		tms = m;
		tdi = d;
		#38;
		// A released tdo reads as the inverse so a missing enable cannot pass as data
		o = tdo_oe ? tdo : ~tdo;
		tck = 1'b1;
		#40;
		tck = 1'b0;
	endtask : step
	// Tdi keeps toggling outside shifts so stale levels never pass as data
	task automatic nav(input logic m);
		logic o;
		step(m, ~tdi, o);
	endtask : nav
	task automatic trst_pulse;
		trst_n = 1'b0;
		nav(1'b1);
		nav(1'b1);
		// Release off the falling edge that clocks the tdo flops
		#2;
		trst_n = 1'b1;
		nav(1'b0);
	endtask : trst_pulse
	task automatic reset5;
		repeat (5) nav(1'b1);
		nav(1'b0);
	endtask : reset5
	// From Run-Test-Idle back to Run-Test-Idle
	task automatic ir(input logic [3:0] c, output logic [3:0] cap);
		nav(1'b1);
		nav(1'b1);
		nav(1'b0);
		nav(1'b0);
		for (int i = 0; i < 4; i++)
			step(i == 3, c[i], cap[i]);
		nav(1'b1);
		nav(1'b0);
	endtask : ir
	task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
		dout = '0;
		nav(1'b1);
		nav(1'b0);
		nav(1'b0);
		for (int i = 0; i < n; i++)
			step(i == n - 1, din[i], dout[i]);
		nav(1'b1);
		nav(1'b0);
	endtask : dr
endmodule : bsd_jtag_host
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the boundary-scan decode block.
// Assumes the host model drives the TAP and this module drives the core side.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bsd_pkg::*;
	logic mclk, rst_n, tck, trst_n, tms, tdi, tdo, tdo_oe;
	logic [BSD_NO-1:0] core_out, core_oe, pin_out, pin_oe;
	logic [BSD_NI-1:0] core_in, pin_in;
	int miscompares = 0;
	int tests_run = 0;
	logic [31:0] d;
	logic [3:0] cap;
	bsd_tap_decode u_dut (.mclk(mclk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	bsd_jtag_host u_host (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Crossing to mclk takes a few cycles; twelve leaves margin
	task automatic settle;
		repeat (12) @(posedge mclk);
		#2;
	endtask : settle
	task automatic summarize;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_idcode;
		u_host.dr(32, 32'h0, d);
		chk("idcode", BSD_ID_WORD, d);
		chk("pin_oe", core_oe, pin_oe);
		u_host.ir(BSD_IR_IDCODE, cap);
		u_host.dr(32, 32'h0, d);
		chk("idcode", BSD_ID_WORD, d);
	endtask : t_idcode
	task automatic t_bypass;
		for (int c = 3; c < 16; c++)
		begin
			if (c == 4)
				continue;
			u_host.ir(4'(c), cap);
			chk("ir_capture", 4'h1, cap);
			u_host.dr(2, 32'h1, d);
			chk("bypass", 32'h2, d);
			settle();
			core_out = 4'(c);
			settle();
			chk("pin_out", core_out, pin_out);
		end
	endtask : t_bypass
	task automatic t_extest;
		core_out = 4'h6;
		u_host.ir(BSD_IR_SAMPLE, cap);
		u_host.dr(12, {20'h0, 4'hc, 4'ha, 4'h0}, d);
		chk("sample", {20'h0, 4'h9, 4'h6, 4'h5}, d);
		settle();
		chk("pin_out", 4'h6, pin_out);
		u_host.ir(BSD_IR_EXTEST, cap);
		settle();
		chk("pin_out", 4'ha, pin_out);
		chk("pin_oe", 4'hc, pin_oe);
		pin_in = 4'h3;
		u_host.dr(12, {20'h0, 4'h3, 4'h5, 4'h0}, d);
		chk("extest_in", 4'h3, d[3:0]);
		chk("extest_cells", 8'hca, d[11:4]);
		settle();
		chk("pin_out", 4'h5, pin_out);
		chk("pin_oe", 4'h3, pin_oe);
	endtask : t_extest
	task automatic t_highz;
		u_host.ir(BSD_IR_HIGHZ, cap);
		settle();
		chk("pin_oe", 4'h0, pin_oe);
		u_host.dr(8, 32'ha5, d);
		chk("highz_path", 32'h4a, d);
		chk("pin_oe", 4'h0, pin_oe);
	endtask : t_highz
	task automatic t_tmsreset;
		u_host.reset5();
		pin_in = 4'ha;
		settle();
		chk("pin_oe", core_oe, pin_oe);
		chk("core_in", 4'ha, core_in);
		u_host.dr(32, 32'h0, d);
		chk("idcode", BSD_ID_WORD, d);
	endtask : t_tmsreset
	initial
	begin
		rst_n = 1'b0;
		core_out = 4'h6;
		core_oe = 4'h9;
		pin_in = 4'h5;
		repeat (16) @(posedge mclk);
		#2;
		rst_n = 1'b1;
		u_host.trst_pulse();
		t_idcode();
		t_bypass();
		t_extest();
		t_highz();
		t_tmsreset();
		summarize();
	end
	// Whole run needs well under a millisecond
	initial
	begin
		#2000000;
		miscompares++;
		summarize();
	end
endmodule : tb
`default_nettype wire
